// ---- rbp_buffer.sv ----
// 28-bit registered command buffer with dual copies and parity check
`include "rbp_cfg.svh"

module rbp_buffer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic buffer_reset_n,
  input wire logic config_select,
  input wire logic chip_select_gate_enable,
  input wire logic [27:0] data_in,
  input wire logic parity_bit_in,
  input wire logic chip_select0_in_n,
  input wire logic chip_select1_in_n,
  input wire logic chip_select2_in_n,
  input wire logic chip_select3_in_n,
  input wire logic clock_enable0_in,
  input wire logic clock_enable1_in,
  input wire logic termination0_in,
  input wire logic termination1_in,
  output logic [27:0] registered_data_out_a,
  output logic [27:0] registered_data_out_b,
  output logic chip_select0_redriven_out,
  output logic chip_select1_redriven_out,
  output logic [1:0] clock_enable_out,
  output logic [1:0] termination_out,
  output logic parity_error_out_n
);

  rbp_pkg::rbp_state_t s_reg;
  rbp_pkg::rbp_state_t s_next;
  logic data_gated;
  logic low_power_gating_mode;
  logic [3:0] chip_select_inputs_n;
  logic word_odd;

  rbp_par_if par ();

  // ------------------------------------------------------------------
  // parity checker
  // ------------------------------------------------------------------
  assign par.word = data_in;
  assign par.cfg_sel = config_select;
  assign par.parity_bit = parity_bit_in;

  rbp_parity u_parity (
    .clk(clk),
    .sys_rst(sys_rst),
    .buffer_reset_n(buffer_reset_n),
    .par(par)
  );

  // ------------------------------------------------------------------
  // gating decode
  // ------------------------------------------------------------------
  assign chip_select_inputs_n = {chip_select3_in_n, chip_select2_in_n,
                                 chip_select1_in_n, chip_select0_in_n};
  // data gating looks at selects 0 and 1 only
  assign data_gated = chip_select_gate_enable & chip_select0_in_n
                      & chip_select1_in_n;
  assign low_power_gating_mode = &chip_select_inputs_n;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // covered-bit mask for the selected arrangement
  function automatic logic [27:0] cover_mask(input logic c);
    cover_mask = c ? `RBP_MASK_CFG_B : `RBP_MASK_CFG_A;
  endfunction : cover_mask

  // bit order of copy b in the second arrangement
  function automatic logic [27:0] mirror28(input logic [27:0] w);
    mirror28 = {<<{w}};
  endfunction : mirror28

  // odd count of ones over the covered bits of this word
  assign word_odd = ^(data_in & cover_mask(config_select));

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (!data_gated) begin
      s_next.data_a_reg = data_in;
      // second arrangement mirrors the copy b pin order
      s_next.data_b_reg = config_select ? mirror28(data_in) : data_in;
    end
    s_next.cs_reg = {chip_select1_in_n, chip_select0_in_n};
    s_next.cke_reg = {clock_enable1_in, clock_enable0_in};
    s_next.odt_reg = {termination1_in, termination0_in};
    // frozen counter carries a pending hold across low power
    if (!low_power_gating_mode) begin
      if (par.err) begin
        s_next.err_n_reg = 1'b0;
        s_next.hold_reg = `RBP_ERR_HOLD;
      end else if (s_reg.hold_reg) begin
        s_next.hold_reg = 1'b0;
      end else begin
        s_next.err_n_reg = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  // outputs change only on a clock edge or when buffer_reset_n falls
  always_ff @(posedge clk or negedge buffer_reset_n) begin
    if (!buffer_reset_n) begin
      s_reg.data_a_reg <= `RBP_DATA_RST;
      s_reg.data_b_reg <= `RBP_DATA_RST;
      s_reg.cs_reg <= `RBP_CTRL_RST;
      s_reg.cke_reg <= `RBP_CTRL_RST;
      s_reg.odt_reg <= `RBP_CTRL_RST;
      s_reg.err_n_reg <= `RBP_ERR_N_RST;
      s_reg.hold_reg <= 1'b0;
    end else if (sys_rst) begin
      s_reg.data_a_reg <= `RBP_DATA_RST;
      s_reg.data_b_reg <= `RBP_DATA_RST;
      s_reg.cs_reg <= `RBP_CTRL_RST;
      s_reg.cke_reg <= `RBP_CTRL_RST;
      s_reg.odt_reg <= `RBP_CTRL_RST;
      s_reg.err_n_reg <= `RBP_ERR_N_RST;
      s_reg.hold_reg <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign registered_data_out_a = s_reg.data_a_reg;
  assign registered_data_out_b = s_reg.data_b_reg;
  assign chip_select0_redriven_out = s_reg.cs_reg[0];
  assign chip_select1_redriven_out = s_reg.cs_reg[1];
  assign clock_enable_out = s_reg.cke_reg;
  assign termination_out = s_reg.odt_reg;
  assign parity_error_out_n = s_reg.err_n_reg;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_reset_clears_out: assert property (
    @(posedge clk) disable iff (!buffer_reset_n)
    sys_rst |=> registered_data_out_a == '0 && registered_data_out_b == '0
      && !chip_select0_redriven_out && parity_error_out_n)
    else $error("outputs not cleared by reset");

  a_reset_beats_gate: assert property (
    @(posedge clk) disable iff (!buffer_reset_n)
    (sys_rst && data_gated) |=> registered_data_out_a == '0
      && parity_error_out_n)
    else $error("gating overrode reset");

  a_gate_holds_data: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    data_gated |=> $stable(registered_data_out_a)
      && $stable(registered_data_out_b))
    else $error("gated data output changed");

  a_data_follows_in: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    !data_gated |=> registered_data_out_a == $past(data_in))
    else $error("data not registered");

  a_copy_arrangement: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    (!data_gated && !config_select) |=>
      registered_data_out_b == registered_data_out_a)
    else $error("copies differ in first arrangement");

  a_err_freeze_lp: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    low_power_gating_mode |=> $stable(parity_error_out_n))
    else $error("error output moved in low power");

  a_err_min_low: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    $fell(parity_error_out_n) |=> !parity_error_out_n)
    else $error("error output low for one cycle only");

  a_err_to_out: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    (par.err && !low_power_gating_mode) |=> !parity_error_out_n)
    else $error("detected error not shown");

  a_cs_redrive: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    1'b1 |=> chip_select1_redriven_out == $past(chip_select1_in_n))
    else $error("chip select not redriven");

  a_cs0_redrive: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    1'b1 |=> chip_select0_redriven_out == $past(chip_select0_in_n))
    else $error("chip select 0 not redriven");

  a_cke_redrive: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    1'b1 |=> clock_enable_out == $past({clock_enable1_in, clock_enable0_in}))
    else $error("clock enables not redriven");

  a_odt_redrive: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    1'b1 |=> termination_out == $past({termination1_in, termination0_in}))
    else $error("terminations not redriven");

  a_copy_mirror: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    (!data_gated && config_select) |=>
      registered_data_out_b == mirror28(registered_data_out_a))
    else $error("copy b not mirrored in second arrangement");

  a_copy_b_follows: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    (!data_gated && !config_select) |=>
      registered_data_out_b == $past(data_in))
    else $error("copy b not registered");

  a_odd_word_late: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    word_odd ##1 !parity_bit_in ##1 !low_power_gating_mode |=>
      !parity_error_out_n)
    else $error("odd word error not shown two cycles on");

  a_even_word_late: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    !word_odd ##1 parity_bit_in ##1 !low_power_gating_mode |=>
      !parity_error_out_n)
    else $error("bad parity bit error not shown");

  a_odd_word_ok: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    word_odd ##1 parity_bit_in |=> !par.err)
    else $error("valid odd word flagged");

  a_even_word_ok: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    !word_odd ##1 !parity_bit_in |=> !par.err)
    else $error("valid even word flagged");

  a_err_stays_high: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    (parity_error_out_n && !par.err) |=> parity_error_out_n)
    else $error("error output fell without error");

  a_err_returns_high: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    (!parity_error_out_n && !par.err && !low_power_gating_mode) ##1
      (!par.err && !low_power_gating_mode) |=> parity_error_out_n)
    else $error("error output held too long");

  a_err_hold_lp: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    (!parity_error_out_n && low_power_gating_mode) |=> !parity_error_out_n)
    else $error("error released in low power");

  a_err_cs3_active: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    (par.err && !chip_select3_in_n) |=> !parity_error_out_n)
    else $error("select 3 did not enable error output");

  a_reset_ctrl_low: assert property (
    @(posedge clk) disable iff (!buffer_reset_n)
    sys_rst |=> clock_enable_out == '0 && termination_out == '0
      && !chip_select1_redriven_out)
    else $error("control outputs not cleared by reset");

  a_async_clears: assert property (
    @(posedge clk)
    !buffer_reset_n |-> registered_data_out_a == '0
      && registered_data_out_b == '0 && parity_error_out_n)
    else $error("async reset did not clear outputs");

  a_release_low: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    ($rose(buffer_reset_n) && data_in == '0) |=>
      registered_data_out_a == '0 && registered_data_out_b == '0)
    else $error("outputs glitched after reset release");

endmodule : rbp_buffer

// ---- rbp_cfg.svh ----
// timing counts, parity masks and reset values of the registered buffer
`ifndef RBP_CFG_SVH
`define RBP_CFG_SVH

`define RBP_WORD_W 28
// covered data bits, bit i is input i+1
`define RBP_MASK_CFG_A 28'h fff0f5f
`define RBP_MASK_CFG_B 28'h faf0fff
// extra cycles an error output stays low after it falls
`define RBP_ERR_HOLD 1'h1
`define RBP_DATA_RST 28'h0000000
`define RBP_CTRL_RST 2'h0
`define RBP_ERR_N_RST 1'h1

`endif

// ---- rbp_pkg.sv ----
// types shared by the registered buffer modules
package rbp_pkg;

  typedef logic [27:0] rbp_word_t;

  typedef struct packed {
    rbp_word_t word_reg;
    logic err_reg;
  } rbp_chk_state_t;

  typedef struct packed {
    rbp_word_t data_a_reg;
    rbp_word_t data_b_reg;
    logic [1:0] cs_reg;
    logic [1:0] cke_reg;
    logic [1:0] odt_reg;
    logic err_n_reg;
    logic hold_reg;
  } rbp_state_t;

endpackage : rbp_pkg

// ---- rbp_par_if.sv ----
// carrier between the buffer core and its parity checker
interface rbp_par_if;
  logic [27:0] word;
  logic cfg_sel;
  logic parity_bit;
  logic err;
  modport core (output word, output cfg_sel, output parity_bit, input err);
  modport chk (input word, input cfg_sel, input parity_bit, output err);
endinterface : rbp_par_if

// ---- rbp_parity.sv ----
// even parity checker with one cycle parity delay
`include "rbp_cfg.svh"

module rbp_parity (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic buffer_reset_n,
  rbp_par_if.chk par
);

  rbp_pkg::rbp_chk_state_t s_reg;
  rbp_pkg::rbp_chk_state_t s_next;

  function automatic logic odd_ones(input logic [27:0] w, input logic c);
    odd_ones = ^(w & (c ? `RBP_MASK_CFG_B : `RBP_MASK_CFG_A));
  endfunction : odd_ones

  // ------------------------------------------------------------------
  // pairing of word with the later parity bit
  // ------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.word_reg = par.word;
    // word from last edge, parity bit from this edge
    s_next.err_reg = odd_ones(s_reg.word_reg, par.cfg_sel) ^ par.parity_bit;
  end

  always_ff @(posedge clk or negedge buffer_reset_n) begin
    if (!buffer_reset_n) begin
      s_reg <= '0;
    end else if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign par.err = s_reg.err_reg;

  a_even_parity_pair: assert property (
    @(posedge clk) disable iff (sys_rst || !buffer_reset_n)
    $past(sys_rst, 2) == 1'b0 |->
    s_reg.err_reg == (odd_ones($past(par.word, 2), $past(par.cfg_sel))
      ^ $past(par.parity_bit)))
    else $error("parity not paired with earlier word");

endmodule : rbp_parity

// ---- rbp_ctrl_model.sv ----
// controller side model: sends words, parity one edge later
`include "rbp_cfg.svh"

module rbp_ctrl_model (
  input wire logic clk,
  input wire logic config_select,
  input wire logic [27:0] send_word,
  input wire logic inject,
  output logic [27:0] data_in,
  output logic parity_bit_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [27:0] mask;

  assign mask = config_select ? `RBP_MASK_CFG_B : `RBP_MASK_CFG_A;
  assign data_in = send_word;
  // inject flips the parity of the word sent one edge earlier
  always @(posedge clk) begin
    parity_bit_in <= ^(data_in & mask) ^ inject;
  end
endmodule : rbp_ctrl_model

// ---- test_rbp_buffer.sv ----
// self-checking bench of the registered buffer with parity
module test_rbp_buffer;
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // signals
  // ----
  logic clk = 1'b0, sys_rst = 1'b1, brst_n = 1'b1, cfg = 1'b0;
  logic gate = 1'b0, g_next = 1'b0, inj = 1'b0;
  logic [3:0] cs_n = 4'he;
  logic [27:0] sw = 28'h0, cur_w = 28'h0, exp_q = 28'h0;
  logic [27:0] din, qa, qb;
  logic [1:0] cke_o, odt_o;
  logic cs0_o, cs1_o, err_n, par;
  int bad_count = 0;
  int num_checks = 0;

  rbp_ctrl_model i_ctrl (.clk(clk), .config_select(cfg), .send_word(sw),
    .inject(inj), .data_in(din), .parity_bit_in(par));
  rbp_buffer i_dut (.clk(clk), .sys_rst(sys_rst), .buffer_reset_n(brst_n),
    .config_select(cfg), .chip_select_gate_enable(gate), .data_in(din),
    .parity_bit_in(par), .chip_select0_in_n(cs_n[0]),
    .chip_select1_in_n(cs_n[1]), .chip_select2_in_n(cs_n[2]),
    .chip_select3_in_n(cs_n[3]), .clock_enable0_in(din[26]),
    .clock_enable1_in(din[27]), .termination0_in(din[24]),
    .termination1_in(din[25]), .registered_data_out_a(qa),
    .registered_data_out_b(qb), .chip_select0_redriven_out(cs0_o),
    .chip_select1_redriven_out(cs1_o), .clock_enable_out(cke_o),
    .termination_out(odt_o), .parity_error_out_n(err_n));

  initial forever #2 clk = ~clk;
  initial begin
    #20000 bad_count++;
    close_out;
  end
  // ----
  // compare tasks
  // ----
  task chk_w(input logic [27:0] got, input logic [27:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk_w
  task chk_e(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: error out %b expected %b", $time, got, exp);
    end
  endtask : chk_e
  task chk_all(input logic [27:0] e, input logic [5:0] c, input logic ex);
    logic [27:0] m;
    m = {<<{e}};
    chk_w(qa, e);
    chk_w(qb, cfg ? m : e);
    chk_w({22'h0, cke_o, odt_o, cs1_o, cs0_o}, {22'h0, c});
    chk_e(err_n, ex);
  endtask : chk_all
  task close_out;
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // ----
  // access: one clock edge per word
  // ----
  task step(input logic [27:0] w, input logic bad, input logic [3:0] cs,
            input logic ex);
    logic [5:0] c;
    @(posedge clk);
    c = {cur_w[27:24], cs_n[1:0]};
    if (!(gate && cs_n[0] && cs_n[1])) exp_q = cur_w;
    sw <= w;
    inj <= bad;
    cs_n <= cs;
    gate <= g_next;
    cur_w = w;
    #1 chk_all(exp_q, c, ex);
  endtask : step
  task seq(input logic [7:0] bads, input logic [7:0] lp,
           input logic [3:0] lcs, input logic [7:0] ex);
    for (int i = 0; i < 8; i++) begin
      step(28'h35a0f1c ^ {7{i[3:0]}}, bads[i], lp[i] ? lcs : 4'he, ex[i]);
    end
  endtask : seq
  task traffic;
    logic [27:0] w;
    w = 28'h1;
    for (int i = 0; i < 8; i++) begin
      w = w * 28'h0000007 + 28'h13579bd;
      step(w, 1'b0, ~(4'h1 << i[1:0]), 1'b1);
    end
  endtask : traffic
  // ----
  // scenarios
  // ----
  initial begin
    repeat (7) @(posedge clk);
    #1 chk_all(28'h0, 6'h0, 1'b1);
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) step(28'h0, 1'b0, 4'he, 1'b1);
    traffic;
    seq(8'h01, 8'h00, 4'hf, 8'he7);
    seq(8'h07, 8'h00, 4'hf, 8'h87);
    seq(8'h01, 8'h18, 4'hf, 8'h87);
    seq(8'h01, 8'h18, 4'h7, 8'he7);
    for (int i = 0; i < 6; i++) begin
      g_next = (i < 4);
      step(28'h35a0f1c ^ {i[3:0], 12'h0}, 1'b0, 4'hb, 1'b1);
    end
    g_next = 1'b1;
    step(28'h0000021, 1'b1, 4'he, 1'b1);
    repeat (2) step(28'h0, 1'b0, 4'he, 1'b1);
    step(28'h0, 1'b0, 4'hf, 1'b0);
    @(posedge clk);
    brst_n <= 1'b0;
    cs_n <= 4'hx;
    gate <= 1'bx;
    #1 chk_all(28'h0, 6'h0, 1'b1);
    repeat (2) @(posedge clk);
    #1 chk_all(28'h0, 6'h0, 1'b1);
    @(posedge clk);
    brst_n <= 1'b1;
    cs_n <= 4'he;
    gate <= 1'b0;
    g_next = 1'b0;
    exp_q = 28'h0;
    repeat (2) step(28'h0, 1'b0, 4'he, 1'b1);
    @(posedge clk);
    sys_rst <= 1'b1;
    gate <= 1'b1;
    cs_n <= 4'hb;
    @(posedge clk);
    cfg <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    gate <= 1'b0;
    cs_n <= 4'he;
    traffic;
    seq(8'h01, 8'h00, 4'hf, 8'he7);
    close_out;
  end
endmodule : test_rbp_buffer
